// ==== design/ebcsd_pkg.sv ====
// Purpose: Shared constants and types for the chip select decoder.
// Assumes: Register index times four gives the byte address.
// Notes:   Timing counts derive from the clock and double clock periods.
package ebcsd_pkg;
	localparam int CLK_PERIOD_NS  = 4;
	localparam int PER2_PERIOD_NS = 8;
	localparam int PER2_DIV = (PER2_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1 :
		PER2_PERIOD_NS / CLK_PERIOD_NS;
	localparam int NUM_CS   = 4;
	localparam int SDRAM_CS = 3;
	// Register indices; byte address is four times the index.
	localparam logic [5:0] CTL_A_IDX    = 6'h00;
	localparam logic [5:0] CTL_B_IDX    = 6'h01;
	localparam logic [5:0] BASE_IDX     = 6'h02;
	localparam logic [5:0] CS_STRIDE    = 6'h04;
	localparam logic [5:0] GLOBAL_IDX   = 6'h10;
	localparam logic [5:0] DLY_IDX      = 6'h11;
	localparam logic [5:0] IRQ_STAT_IDX = 6'h12;
	localparam logic [5:0] IRQ_MASK_IDX = 6'h13;
	// Field positions and values.
	localparam int         SIZE_LSB    = 2;
	localparam int         SR_BIT      = 2;
	localparam int         DONE_BIT    = 7;
	localparam int         BASE_LSB    = 4;
	localparam logic [4:0] SIZE_FULL   = 5'h10;
	localparam logic [4:0] SIZE_LINE0  = 5'h08;
	localparam int         DLY_W       = 14;
	localparam int         IRQ_W       = 4;
	localparam int         IRQ_INIT    = 0;
	localparam int         IRQ_SR      = 1;
	localparam int         IRQ_ACC     = 2;
	localparam int         IRQ_MISS    = 3;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {
		MODE_OFF = 2'h0, MODE_SRAM = 2'h1, MODE_LOWPIN = 2'h2, MODE_SDRAM = 2'h3
	} ebcsd_mode_t;
	typedef enum logic [2:0] {
		CMD_NOP, CMD_PRECH, CMD_REFR, CMD_LOADMODE, CMD_SR_ENTER, CMD_SR_EXIT
	} ebcsd_cmd_t;
	typedef struct packed {
		logic [4:0]  size;
		ebcsd_mode_t mode;
		logic [2:0]  ctlb;
		logic [11:0] base;
	} ebcsd_cfg_t;
endpackage

// ==== design/ebcsd_top.sv ====
// Purpose: Chip select configuration registers and address decoder.
// Assumes: AXI4-Lite register access; access requests come from the same clock.
// Notes:   Timing runs on a one-cycle double clock enable from a divider.
// Operation
// - Size code picks 256B to 8MB block
// - Region extends upward from base by size; the code uses the size-aligned block that holds base
// - Code 10000 covers all; higher reserved
// - Mode selects off, SRAM, low-pin, SDRAM
// - Second register layout follows select mode
// - SRAM accesses stretched by 0 to 7
// - Init flag sets when init sequence ends
// - Init flag holds while enabled and SDRAM
// - Writing one sends self-refresh command
// - Access type 00 gives ordinary accesses
// - Access type 01 issues load-mode command
// - Base holds address bits 23 to 12
// - Region formed from base and size
// - Init: delay, precharge, refresh, load mode
`timescale 1ns/1ps
`default_nettype none
module ebcsd_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [7:0]           s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [7:0]           s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 acc_valid,
	input  wire logic [23:0]          acc_addr,
	output logic [3:0]                cs_sel_q,
	output ebcsd_pkg::ebcsd_mode_t    acc_mode_q,
	output logic                      acc_done_q,
	output logic                      acc_miss_q,
	output ebcsd_pkg::ebcsd_cmd_t     sdram_cmd_q,
	output logic                      sdram_cmd_valid_q,
	output logic                      irq_q
);
	typedef enum logic [1:0] {A_IDLE, A_WAIT, A_LOAD, A_DONE} ebcsd_acc_t;
	typedef enum logic [2:0] {I_OFF, I_DELAY, I_PRECH, I_REFR, I_LOAD, I_READY} ebcsd_init_t;
	localparam int CMD_BOUND = 4;

	ebcsd_pkg::ebcsd_cfg_t cfg_q [ebcsd_pkg::NUM_CS];
	logic                          bus_en_q;
	logic [ebcsd_pkg::DLY_W-1:0]   dly_q, dly_cnt_q;
	logic [ebcsd_pkg::IRQ_W-1:0]   irq_stat_q, irq_mask_q, irq_set;
	logic [7:0]                    waddr_q;
	logic [31:0]                   wdata_q;
	logic [3:0]                    wstrb_q;
	logic                          wr_en, wr_ok, rd_ok;
	logic [31:0]                   rd_val;
	logic [$clog2(ebcsd_pkg::PER2_DIV+1)-1:0] div_q;
	logic                          tick;
	ebcsd_acc_t                    acc_state_q;
	ebcsd_init_t                   init_state_q;
	logic [1:0]                    sel_idx_q, hit_idx;
	logic                          any_hit;
	logic [3:0]                    hit_vec;
	logic [23:0]                   acc_addr_q;
	logic [2:0]                    wait_cnt_q, wait_lat_q;
	logic [3:0]                    wticks_q;
	logic                          init_done_q, sd_on, init_req, sr_enter_q, sr_exit_q;
	logic                          grant_sr, grant_ld;

	// Region mask: ones on the compared lines, none for the whole space.
	function automatic logic [23:0] reg_mask(input logic [4:0] size);
		reg_mask = (size >= ebcsd_pkg::SIZE_FULL) ? 24'h000000 :
			24'hFFFFFF << (size + ebcsd_pkg::SIZE_LINE0);
	endfunction

	// Base bits 11:8 are held at zero, so small regions sit on 4KB steps.
	function automatic logic hit(input ebcsd_pkg::ebcsd_cfg_t c, input int k,
		input logic [23:0] a);
		logic [23:0] m;
		m   = reg_mask(c.size);
		hit = (c.mode != ebcsd_pkg::MODE_OFF) && (c.size <= ebcsd_pkg::SIZE_FULL)
			&& (k == ebcsd_pkg::SDRAM_CS || c.mode != ebcsd_pkg::MODE_SDRAM)
			&& (((a ^ {c.base, 12'h000}) & m) == 24'h000000);
	endfunction

	// Register index decode; non-word offsets and holes are unmapped.
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a[1:0] == 2'h0) && ((a[7:6] == 2'h0 && a[3:2] != 2'h3) ||
			(a[7:2] >= ebcsd_pkg::GLOBAL_IDX && a[7:2] <= ebcsd_pkg::IRQ_MASK_IDX));
	endfunction

	// Double clock enable: one pulse every PER2_DIV cycles.
	always_ff @(posedge aclk) begin
		if (!aresetn || div_q == $bits(div_q)'(ebcsd_pkg::PER2_DIV - 1)) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end
	assign tick = (div_q == $bits(div_q)'(ebcsd_pkg::PER2_DIV - 1));

	// Write channel: address and data are taken in either order, response follows both.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ebcsd_pkg::RESP_OKAY;
			waddr_q       <= 8'h00;
			wdata_q       <= 32'h00000000;
			wstrb_q       <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				waddr_q       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata;
				wstrb_q      <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_en) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? ebcsd_pkg::RESP_OKAY : ebcsd_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end
	assign wr_en = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_ok = mapped(waddr_q);

	// Read data mux; the second register shows the layout of its mode.
	always_comb begin
		ebcsd_pkg::ebcsd_cfg_t c;
		c      = cfg_q[s_axi_araddr[5:4]];
		rd_ok  = mapped(s_axi_araddr);
		rd_val = 32'h00000000;
		if (s_axi_araddr[7:6] == 2'h0) begin
			unique case (s_axi_araddr[3:2])
				ebcsd_pkg::CTL_A_IDX[1:0]: rd_val[6:0] = {c.size, c.mode};
				ebcsd_pkg::CTL_B_IDX[1:0]: begin
					if (c.mode == ebcsd_pkg::MODE_SDRAM) begin
						rd_val[7:0] = {init_done_q && s_axi_araddr[5:4] == 2'h3,
							4'h0, c.ctlb};
					end else begin
						rd_val[2:0] = c.ctlb;
					end
				end
				ebcsd_pkg::BASE_IDX[1:0]: rd_val[15:0] = {c.base, 4'h0};
				default: rd_val = 32'h00000000;
			endcase
		end else begin
			unique case (s_axi_araddr[7:2])
				ebcsd_pkg::GLOBAL_IDX:   rd_val[0] = bus_en_q;
				ebcsd_pkg::DLY_IDX:      rd_val[ebcsd_pkg::DLY_W-1:0] = dly_q;
				ebcsd_pkg::IRQ_STAT_IDX: rd_val[ebcsd_pkg::IRQ_W-1:0] = irq_stat_q;
				ebcsd_pkg::IRQ_MASK_IDX: rd_val[ebcsd_pkg::IRQ_W-1:0] = irq_mask_q;
				default:                 rd_val = 32'h00000000;
			endcase
		end
	end

	// Read channel answers one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= ebcsd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= rd_val;
			s_axi_rresp   <= rd_ok ? ebcsd_pkg::RESP_OKAY : ebcsd_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Chip select registers; only writable bits are stored, so reserved bits stay zero.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < ebcsd_pkg::NUM_CS; i++) begin
				cfg_q[i] <= '0;
			end
		end else if (wr_en && wr_ok && waddr_q[7:6] == 2'h0) begin
			unique case (waddr_q[3:2])
				ebcsd_pkg::CTL_A_IDX[1:0]: begin
					if (wstrb_q[0]) begin
						cfg_q[waddr_q[5:4]].size <= wdata_q[6:2];
						cfg_q[waddr_q[5:4]].mode <= ebcsd_pkg::ebcsd_mode_t'(wdata_q[1:0]);
					end
				end
				ebcsd_pkg::CTL_B_IDX[1:0]: begin
					if (wstrb_q[0]) begin
						cfg_q[waddr_q[5:4]].ctlb <= wdata_q[2:0];
					end
				end
				ebcsd_pkg::BASE_IDX[1:0]: begin
					if (wstrb_q[0]) begin
						cfg_q[waddr_q[5:4]].base[3:0] <= wdata_q[7:4];
					end
					if (wstrb_q[1]) begin
						cfg_q[waddr_q[5:4]].base[11:4] <= wdata_q[15:8];
					end
				end
				default: ;
			endcase
		end
	end

	// Global enable, start delay and interrupt mask.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bus_en_q   <= 1'b0;
			dly_q      <= '0;
			irq_mask_q <= '0;
		end else if (wr_en && wr_ok) begin
			if (waddr_q[7:2] == ebcsd_pkg::GLOBAL_IDX && wstrb_q[0]) begin
				bus_en_q <= wdata_q[0];
			end
			if (waddr_q[7:2] == ebcsd_pkg::DLY_IDX) begin
				if (wstrb_q[0]) dly_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) dly_q[13:8] <= wdata_q[13:8];
			end
			if (waddr_q[7:2] == ebcsd_pkg::IRQ_MASK_IDX && wstrb_q[0]) begin
				irq_mask_q <= wdata_q[ebcsd_pkg::IRQ_W-1:0];
			end
		end
	end

	// Sticky status: a set in the same cycle as its write-one clear wins.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_q <= '0;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= (irq_stat_q & ~((wr_en && wr_ok && wstrb_q[0] &&
				waddr_q[7:2] == ebcsd_pkg::IRQ_STAT_IDX) ?
				wdata_q[ebcsd_pkg::IRQ_W-1:0] : '0)) | irq_set;
			irq_q <= |(irq_stat_q & irq_mask_q);
		end
	end

	// SDRAM init sequence on the fourth select, paced by the double clock.
	assign sd_on    = bus_en_q && cfg_q[ebcsd_pkg::SDRAM_CS].mode == ebcsd_pkg::MODE_SDRAM;
	assign init_req = init_state_q inside {I_PRECH, I_REFR, I_LOAD};
	always_ff @(posedge aclk) begin
		if (!aresetn || !sd_on) begin
			init_state_q <= I_OFF;
			dly_cnt_q    <= '0;
			init_done_q  <= 1'b0;
		end else begin
			unique case (init_state_q)
				I_OFF: init_state_q <= I_DELAY;
				I_DELAY: begin
					if (tick) begin
						if (dly_cnt_q >= dly_q) init_state_q <= I_PRECH;
						else dly_cnt_q <= dly_cnt_q + 1'b1;
					end
				end
				I_PRECH: if (tick) init_state_q <= I_REFR;
				I_REFR:  if (tick) init_state_q <= I_LOAD;
				I_LOAD: begin
					if (tick) begin
						init_state_q <= I_READY;
						init_done_q  <= 1'b1;
					end
				end
				I_READY: init_state_q <= I_READY;
			endcase
		end
	end

	// Self-refresh requests are taken on a change of the written bit.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sr_enter_q <= 1'b0;
			sr_exit_q  <= 1'b0;
		end else if (wr_en && wr_ok && wstrb_q[0] && sd_on &&
			waddr_q[7:2] == ebcsd_pkg::CS_STRIDE * 3 + ebcsd_pkg::CTL_B_IDX) begin
			if (wdata_q[ebcsd_pkg::SR_BIT] && !cfg_q[3].ctlb[ebcsd_pkg::SR_BIT]) begin
				sr_enter_q <= 1'b1;
			end
			if (!wdata_q[ebcsd_pkg::SR_BIT] && cfg_q[3].ctlb[ebcsd_pkg::SR_BIT]) begin
				sr_exit_q <= 1'b1;
			end
		end else if (grant_sr) begin
			if (sr_enter_q) sr_enter_q <= 1'b0;
			else sr_exit_q <= 1'b0;
		end
	end

	// Command slot: init first, then self-refresh, then load-mode accesses.
	assign grant_sr = tick && !init_req && (sr_enter_q || sr_exit_q);
	assign grant_ld = tick && !init_req && !grant_sr && acc_state_q == A_LOAD;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sdram_cmd_q       <= ebcsd_pkg::CMD_NOP;
			sdram_cmd_valid_q <= 1'b0;
		end else begin
			sdram_cmd_valid_q <= (tick && init_req && sd_on) || grant_sr || grant_ld;
			if (tick && init_req && sd_on) begin
				sdram_cmd_q <= (init_state_q == I_PRECH) ? ebcsd_pkg::CMD_PRECH :
					(init_state_q == I_REFR) ? ebcsd_pkg::CMD_REFR : ebcsd_pkg::CMD_LOADMODE;
			end else if (grant_sr) begin
				sdram_cmd_q <= sr_enter_q ? ebcsd_pkg::CMD_SR_ENTER : ebcsd_pkg::CMD_SR_EXIT;
			end else if (grant_ld) begin
				sdram_cmd_q <= ebcsd_pkg::CMD_LOADMODE;
			end else begin
				sdram_cmd_q <= ebcsd_pkg::CMD_NOP;
			end
		end
	end

	// Lowest numbered matching select wins when regions overlap.
	always_comb begin
		hit_idx = 2'h0;
		any_hit = 1'b0;
		for (int i = ebcsd_pkg::NUM_CS - 1; i >= 0; i--) begin
			hit_vec[i] = hit(cfg_q[i], i, acc_addr);
			if (hit_vec[i]) begin
				hit_idx = 2'(i);
				any_hit = 1'b1;
			end
		end
	end

	// Access sequencer: decode, stretch or issue, then a one-cycle done.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_state_q <= A_IDLE;
			cs_sel_q    <= 4'h0;
			acc_mode_q  <= ebcsd_pkg::MODE_OFF;
			acc_done_q  <= 1'b0;
			acc_miss_q  <= 1'b0;
			sel_idx_q   <= 2'h0;
			acc_addr_q  <= 24'h000000;
			wait_cnt_q  <= 3'h0;
			wait_lat_q  <= 3'h0;
		end else begin
			acc_done_q <= 1'b0;
			unique case (acc_state_q)
				A_IDLE: begin
					if (acc_valid && bus_en_q && !acc_done_q) begin // A request still held while done is high is not retaken.
						acc_addr_q <= acc_addr;
						sel_idx_q  <= hit_idx;
						acc_miss_q <= !any_hit;
						cs_sel_q   <= any_hit ? 4'h1 << hit_idx : 4'h0;
						acc_mode_q <= any_hit ? cfg_q[hit_idx].mode : ebcsd_pkg::MODE_OFF;
						wait_cnt_q <= cfg_q[hit_idx].ctlb;
						wait_lat_q <= cfg_q[hit_idx].ctlb;
						if (!any_hit) acc_state_q <= A_DONE;
						else if (cfg_q[hit_idx].mode != ebcsd_pkg::MODE_SDRAM) acc_state_q <= A_WAIT;
						else if (cfg_q[hit_idx].ctlb[1:0] == 2'h1) acc_state_q <= A_LOAD;
						else acc_state_q <= A_DONE;
					end
				end
				A_WAIT: begin
					if (tick) begin
						if (wait_cnt_q == 3'h0) acc_state_q <= A_DONE;
						else wait_cnt_q <= wait_cnt_q - 1'b1;
					end
				end
				A_LOAD: if (grant_ld) acc_state_q <= A_DONE;
				A_DONE: begin
					acc_done_q  <= 1'b1;
					cs_sel_q    <= 4'h0;
					acc_state_q <= A_IDLE;
				end
			endcase
		end
	end

	assign irq_set = {acc_state_q == A_DONE && acc_miss_q, acc_state_q == A_DONE,
		grant_sr, init_state_q == I_LOAD && tick};

	// Helper for the stretch check: ticks seen while waiting.
	always_ff @(posedge aclk) begin
		if (!aresetn || acc_state_q == A_IDLE) wticks_q <= 4'h0;
		else if (acc_state_q == A_WAIT && tick) wticks_q <= wticks_q + 1'b1;
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_sel_in_region: assert property (|cs_sel_q |-> ((acc_addr_q - ({cfg_q[sel_idx_q].base,
		12'h000} & reg_mask(cfg_q[sel_idx_q].size))) & reg_mask(cfg_q[sel_idx_q].size))
		== 24'h000000) else $error("select outside its region");
	a_rsvd_size_miss: assert property (acc_state_q == A_IDLE && acc_valid && bus_en_q &&
		!acc_done_q && cfg_q[1].size > ebcsd_pkg::SIZE_FULL |=> !cs_sel_q[1])
		else $error("reserved size decoded");
	a_off_no_select: assert property (|cs_sel_q |-> acc_mode_q != ebcsd_pkg::MODE_OFF)
		else $error("disabled select asserted");
	a_sdram_cs_only: assert property (|cs_sel_q[2:0] |-> acc_mode_q != ebcsd_pkg::MODE_SDRAM)
		else $error("SDRAM on wrong select");
	a_wait_stretch: assert property (acc_state_q == A_DONE && $past(acc_state_q) == A_WAIT
		|-> wticks_q == {1'b0, wait_lat_q} + 4'h1) else $error("wait count wrong");
	a_init_flag: assert property ($rose(init_done_q) |-> $past(init_state_q) == I_LOAD
		&& sdram_cmd_q == ebcsd_pkg::CMD_LOADMODE) else $error("flag set early");
	a_init_drop: assert property (init_done_q && !sd_on |=> !init_done_q)
		else $error("flag kept after disable");
	a_init_order: assert property (init_state_q == I_REFR |-> $past(init_state_q) inside
		{I_PRECH, I_REFR}) else $error("refresh out of order");
	a_sr_command: assert property (sr_enter_q && init_state_q == I_READY |-> ##[1:CMD_BOUND]
		sdram_cmd_valid_q && sdram_cmd_q == ebcsd_pkg::CMD_SR_ENTER)
		else $error("self-refresh not sent");
	a_load_access: assert property (acc_state_q == A_LOAD && grant_ld |=> sdram_cmd_valid_q
		&& sdram_cmd_q == ebcsd_pkg::CMD_LOADMODE ##1 acc_done_q)
		else $error("load-mode not issued");
	c_init_ready: cover property (init_state_q == I_LOAD ##1 init_done_q);
	c_wait_seven: cover property (acc_done_q && wticks_q == 4'h8);
	c_load_mode: cover property (grant_ld);
	c_miss: cover property (acc_done_q && acc_miss_q);
endmodule // ebcsd_top
`default_nettype wire

// ==== verif/ebcsd_sdram_model.sv ====
// Purpose: Logging model of the SDRAM that sits on the fourth chip select.
// Assumes: Commands arrive as one-cycle pulses together with their code.
// Notes:   It only records commands; the bench judges their order and count.
`timescale 1ns/1ps
`default_nettype none
module ebcsd_sdram_model (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire ebcsd_pkg::ebcsd_cmd_t cmd,
	input wire logic                  cmd_valid
);
	ebcsd_pkg::ebcsd_cmd_t log_q [32];
	int                    cnt_q;
	// A real part acts on every pulse, so every pulse is logged, even repeated ones.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 0;
		end else if (cmd_valid) begin
			log_q[cnt_q[4:0]] <= cmd;
			cnt_q <= cnt_q + 1;
		end
	end
endmodule // ebcsd_sdram_model
`default_nettype wire

// ==== verif/ext_bus_chip_select_decode_test.sv ====
// Purpose: Self-checking bench for the chip select decoder.
// Assumes: Registers answer over AXI4-Lite; access port per the hand-over timing.
// Notes:   Each scenario is its own task; the SDRAM side is a logging model.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_chip_select_decode_test;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, acc_valid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [23:0] acc_addr;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] cs_sel_q;
	ebcsd_pkg::ebcsd_mode_t acc_mode_q;
	ebcsd_pkg::ebcsd_cmd_t sdram_cmd_q;
	logic acc_done_q, acc_miss_q, sdram_cmd_valid_q, irq_q;
	int error_cnt, cmp_count;

	ebcsd_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(rready), .acc_valid(acc_valid), .acc_addr(acc_addr),
		.cs_sel_q(cs_sel_q), .acc_mode_q(acc_mode_q), .acc_done_q(acc_done_q),
		.acc_miss_q(acc_miss_q), .sdram_cmd_q(sdram_cmd_q),
		.sdram_cmd_valid_q(sdram_cmd_valid_q), .irq_q(irq_q));

	ebcsd_sdram_model mem (.aclk(aclk), .aresetn(aresetn), .cmd(sdram_cmd_q),
		.cmd_valid(sdram_cmd_valid_q));

	// Verdict is printed in one place so a hang and a normal end report alike.
	task automatic close_out;
		$display("comparisons=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// Every wait is bounded; running out counts as a mismatch and ends the run.
	task automatic guard(ref int n);
		n++;
		if (n > 300) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, n, 0);
			close_out;
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		bit ad, wd;
		@(posedge aclk);
		awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
		n = 0; ad = 0; wd = 0;
		while (!(ad && wd)) begin
			@(posedge aclk);
			guard(n);
			if (!ad && s_axi_awready === 1'b1) begin ad = 1; awvalid <= 1'b0; end
			if (!wd && s_axi_wready === 1'b1) begin wd = 1; wvalid <= 1'b0; end
		end
		do begin @(posedge aclk); guard(n); end while (s_axi_bvalid !== 1'b1);
		bready <= 1'b0;
		chk(s_axi_bresp, ebcsd_pkg::RESP_OKAY);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge aclk);
		araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
		n = 0;
		do begin @(posedge aclk); guard(n); end while (s_axi_arready !== 1'b1);
		arvalid <= 1'b0;
		do begin @(posedge aclk); guard(n); end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata; r = s_axi_rresp;
		rready <= 1'b0;
	endtask

	// The select drops with the done pulse, so it is caught while it stands.
	// The drain after each access lets commands and status settle first.
	task automatic acc(input logic [23:0] a, output logic [3:0] cs, output logic [1:0] md,
		output logic ms, output int lat);
		int n;
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc_addr <= a;
		n = 0;
		cs = 4'h0;
		do begin
			@(posedge aclk);
			guard(n);
			if (cs_sel_q !== 4'h0) cs = cs_sel_q;
		end while (acc_done_q !== 1'b1);
		md = acc_mode_q;
		ms = acc_miss_q;
		lat = n;
		acc_valid <= 1'b0;
		repeat (40) @(posedge aclk);
	endtask

	task automatic wait_cmd(input int k);
		int n;
		n = 0;
		while (mem.cnt_q < k) begin @(posedge aclk); guard(n); end
	endtask

	logic [31:0] d;
	logic [1:0] r, md;
	logic [3:0] cs;
	logic ms;
	int lat0, lat7, k;

	task automatic t_reset;
		rd(8'h00, d, r); chk(d, 32'h0);
		rd(8'h38, d, r); chk(d, 32'h0);
		rd(8'h50, d, r); chk(r, ebcsd_pkg::RESP_SLVERR);
	endtask

	task automatic t_regs;
		wr(8'h00, 32'h81); rd(8'h00, d, r); chk(d, 32'h01);
		wr(8'h08, 32'h123F); rd(8'h08, d, r); chk(d, 32'h1230);
		wr(8'h04, 32'hFF); rd(8'h04, d, r); chk(d, 32'h07);
		wr(8'h40, 32'h1);
	endtask

	task automatic t_decode;
		acc(24'h1230FF, cs, md, ms, lat0); chk({cs, md, ms}, {4'h1, 2'h1, 1'b0});
		acc(24'h123100, cs, md, ms, lat0); chk({cs, ms}, {4'h0, 1'b1});
		acc(24'h122FFF, cs, md, ms, lat0); chk(ms, 1'b1);
		wr(8'h00, 32'h05);
		acc(24'h1231FF, cs, md, ms, lat0); chk({cs, ms}, {4'h1, 1'b0});
	endtask

	task automatic t_full;
		wr(8'h00, 32'h00);
		acc(24'h1230FF, cs, md, ms, lat0); chk({cs, ms}, {4'h0, 1'b1});
		wr(8'h10, 32'h42);
		acc(24'hFFFFFF, cs, md, ms, lat0); chk({cs, md, ms}, {4'h2, 2'h2, 1'b0});
		wr(8'h10, 32'h46);
		acc(24'hFFFFFF, cs, md, ms, lat0); chk({cs, ms}, {4'h0, 1'b1});
		wr(8'h10, 32'h43);
		acc(24'hFFFFFF, cs, md, ms, lat0); chk({cs, ms}, {4'h0, 1'b1});
	endtask

	// The tick phase is unknown, so the 7-state stretch may land one cycle either way.
	task automatic t_wait;
		wr(8'h10, 32'h41); wr(8'h14, 32'h0);
		acc(24'h000000, cs, md, ms, lat0); chk({cs, md}, {4'h2, 2'h1});
		wr(8'h14, 32'h7);
		acc(24'h000000, cs, md, ms, lat7);
		chk(lat7 - lat0 >= 13 && lat7 - lat0 <= 15, 1'b1);
		wr(8'h10, 32'h0);
	endtask

	task automatic t_init;
		int n;
		wr(8'h44, 32'h2); wr(8'h4C, 32'h1); wr(8'h30, 32'h43);
		n = 0;
		do begin rd(8'h48, d, r); guard(n); end while (d[0] !== 1'b1);
		chk(mem.cnt_q, 3);
		chk({mem.log_q[0], mem.log_q[1], mem.log_q[2]},
			{ebcsd_pkg::CMD_PRECH, ebcsd_pkg::CMD_REFR, ebcsd_pkg::CMD_LOADMODE});
		rd(8'h34, d, r); chk(d[7], 1'b1);
		repeat (2) @(posedge aclk);
		chk(irq_q, 1'b1);
		wr(8'h4C, 32'h0); repeat (2) @(posedge aclk); chk(irq_q, 1'b0);
		wr(8'h4C, 32'h1); wr(8'h48, 32'h1); repeat (2) @(posedge aclk); chk(irq_q, 1'b0);
	endtask

	task automatic t_refresh;
		k = mem.cnt_q;
		wr(8'h34, 32'h4); wait_cmd(k + 1);
		chk(mem.log_q[k], ebcsd_pkg::CMD_SR_ENTER);
		wr(8'h34, 32'h0); wait_cmd(k + 2);
		chk(mem.log_q[k + 1], ebcsd_pkg::CMD_SR_EXIT);
		rd(8'h34, d, r); chk(d, 32'h80);
	endtask

	task automatic t_sdram_acc;
		wr(8'h34, 32'h1); k = mem.cnt_q;
		acc(24'h000010, cs, md, ms, lat0); chk({cs, md}, {4'h8, 2'h3});
		chk(mem.cnt_q > k && mem.log_q[k] === ebcsd_pkg::CMD_LOADMODE, 1'b1);
		wr(8'h34, 32'h0); k = mem.cnt_q;
		acc(24'h000010, cs, md, ms, lat0); chk({cs, ms}, {4'h8, 1'b0});
		chk(mem.cnt_q, k);
	endtask

	// The clock is free-running at 250 MHz.
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	// Every input has a value at time zero; reset is held for four edges.
	initial begin
		aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
		rready = 1'b0; acc_valid = 1'b0; awaddr = 8'h00; araddr = 8'h00;
		wdata = 32'h0; acc_addr = 24'h0; error_cnt = 0; cmp_count = 0;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset;
		t_regs;
		t_decode;
		t_full;
		t_wait;
		t_init;
		t_refresh;
		t_sdram_acc;
		close_out;
	end
endmodule // ext_bus_chip_select_decode_test
`default_nettype wire
